// ---- event_flags_defines.svh ----
// Register offsets, reset values and field positions of the event flag block
`ifndef EVENT_FLAGS_DEFINES_SVH
`define EVENT_FLAGS_DEFINES_SVH

// Register offsets
`define ADDR_REF_FAIL_IRQ_STATUS 8'h02
`define ADDR_LOOP_EVENT_STATUS 8'h03
`define ADDR_REF_FAIL_IRQ_MASK 8'h04
`define ADDR_LOOP_EVENT_IRQ_MASK 8'h05
`define ADDR_MON_FLAGS_HI 8'h06
`define ADDR_MON_FLAGS_LO 8'h07
`define ADDR_MON_MASK_HI 8'h08
`define ADDR_MON_MASK_LO 8'h09
`define ADDR_LOSS_PIN_SELECT 8'h10

// Reset values
`define RST_FLAGS 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_MON_MASK 8'h66
`define RST_LOSS_PIN_SELECT 8'h00
`define RST_READ_DATA 8'h00

// Field geometry
`define REF_COUNT 4
`define LOOP_COUNT 4
`define FLAG_NIBBLE 4
`define REG_WIDTH 8
`define PIN_SEL_WIDTH 2
`define MAX_LOSS_PINS 4

`endif

// ---- event_flags_pkg.sv ----
// Types shared by the event flag block
package event_flags_pkg;

   // One register access request, all fields sampled on one clock edge
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   // Per-reference failure nibble, bit 0 is signal loss
   typedef struct packed {
      logic settle_guard;
      logic rough_rate;
      logic single_period;
      logic signal_loss;
   } ref_event_type;

endpackage

// ---- sticky_flag_bank.sv ----
// Bank of sticky flags where a set always wins over a clear
`timescale 1ns/100ps
module sticky_flag_bank #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Set and clear strobes, one bit per flag
   input wire logic [WIDTH-1:0] set_vec,
   input wire logic [WIDTH-1:0] clr_vec,
   // Held flags
   output logic [WIDTH-1:0] flag_vec
);

   // Refuse a bank that holds nothing
   if (WIDTH < 1) begin : g_bad_width
      $error("sticky_flag_bank WIDTH must be at least 1");
   end

   // Flags hold until cleared; an event in the clearing cycle is kept
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_vec <= '0;
      end else begin
         flag_vec <= (flag_vec & ~clr_vec) | set_vec;
      end
   end

endmodule

// ---- ref_monitor_dpll_event_flags.sv ----
// Event flags and masks for reference monitors and loop events
`timescale 1ns/100ps
`include "event_flags_defines.svh"
module ref_monitor_dpll_event_flags
   import event_flags_pkg::*;
#(
   parameter int LOSS_PIN_COUNT = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register access
   input wire reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   // Asynchronous loss-of-signal pins from the line side
   input wire logic [LOSS_PIN_COUNT-1:0] loss_pin,
   // Monitor failure reports, one bit per reference
   input wire logic [3:0] single_period_fail,
   input wire logic [3:0] rough_rate_fail,
   input wire logic [3:0] settle_guard_expire,
   // Loop events, one bit per loop
   input wire logic [3:0] loop_freeze_event,
   input wire logic [3:0] loop_unlock_event,
   // Interrupt request, active high
   output logic irq
);

   // Pin count must fit the select field
   if (LOSS_PIN_COUNT < 1 || LOSS_PIN_COUNT > `MAX_LOSS_PINS) begin : g_bad_pins
      $error("LOSS_PIN_COUNT must be 1 to 4");
   end

   // Software-written masks and select
   logic [7:0] ref_fail_irq_mask_reg; // One bit per reference
   logic [7:0] loop_event_irq_mask_reg; // Two bits per loop
   logic [7:0] ref_monitor_fail_mask_hi_reg; // References 2 and 3
   logic [7:0] ref_monitor_fail_mask_lo_reg; // References 0 and 1
   logic [7:0] loss_pin_select_reg; // Two bits per reference

   // Synchroniser stages and edge history
   logic [LOSS_PIN_COUNT-1:0] loss_meta_reg; // First stage, read only by second
   logic [LOSS_PIN_COUNT-1:0] loss_sync_reg; // Second stage, safe to use
   logic [3:0] ref_loss_prev_reg; // Selected level one cycle earlier
   logic [3:0] ref_loss_level; // Selected synchronised level per reference

   // Event and flag vectors
   ref_event_type [3:0] ref_event; // Set strobes per reference
   logic [15:0] mon_set; // Packed monitor set strobes
   logic [15:0] mon_clr; // Clear strobes from reads
   logic [15:0] mon_flags; // Sticky monitor flags
   logic [15:0] mon_mask; // Monitor masks, same layout
   logic [3:0] ref_irq_set;
   logic [3:0] ref_irq_clr;
   logic [3:0] ref_irq_status;
   logic [7:0] loop_set;
   logic [7:0] loop_clr;
   logic [7:0] loop_status;
   logic read_hit_valid; // Read strobe for this cycle
   logic [7:0] read_value; // Data chosen by address

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loss_meta_reg <= '0;
         loss_sync_reg <= '0;
      end else begin
         loss_meta_reg <= loss_pin;
         loss_sync_reg <= loss_meta_reg;
      end
   end

   always_comb begin
      logic [`PIN_SEL_WIDTH-1:0] sel; // Select field of the reference in hand
      sel = '0;
      for (int r = 0; r < `REF_COUNT; r++) begin
         sel = loss_pin_select_reg[r*`PIN_SEL_WIDTH +: `PIN_SEL_WIDTH];
         // A select beyond the fitted pins reads as no loss
         if (int'(sel) < LOSS_PIN_COUNT) begin
            ref_loss_level[r] = loss_sync_reg[sel];
         end else begin
            ref_loss_level[r] = 1'b0;
         end
      end
   end

   // Edge history of the routed level; changing the select may look like an edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_loss_prev_reg <= '0;
      end else begin
         ref_loss_prev_reg <= ref_loss_level;
      end
   end

   // Gather the four failure kinds per reference
   always_comb begin
      for (int r = 0; r < `REF_COUNT; r++) begin
         ref_event[r].signal_loss = ref_loss_level[r] & ~ref_loss_prev_reg[r];
         ref_event[r].single_period = single_period_fail[r];
         ref_event[r].rough_rate = rough_rate_fail[r];
         ref_event[r].settle_guard = settle_guard_expire[r];
      end
   end

   // flags set with no mask term
   assign mon_set = ref_event;
   assign mon_mask = {ref_monitor_fail_mask_hi_reg, ref_monitor_fail_mask_lo_reg};

   // Reads are the only way software clears a sticky flag
   assign read_hit_valid = reg_req.rd;

   // Reading a flag register clears exactly the bits it returned
   always_comb begin
      mon_clr = '0;
      ref_irq_clr = '0;
      loop_clr = '0;
      if (read_hit_valid) begin
         case (reg_req.addr)
            `ADDR_MON_FLAGS_LO: mon_clr[7:0] = mon_flags[7:0];
            `ADDR_MON_FLAGS_HI: mon_clr[15:8] = mon_flags[15:8];
            `ADDR_REF_FAIL_IRQ_STATUS: ref_irq_clr = ref_irq_status;
            `ADDR_LOOP_EVENT_STATUS: loop_clr = loop_status;
            default: mon_clr = '0;
         endcase
      end
   end

   sticky_flag_bank #(
      .WIDTH(16)
   ) u_mon_flags (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .set_vec(mon_set),
      .clr_vec(mon_clr),
      .flag_vec(mon_flags)
   );

   always_comb begin
      for (int r = 0; r < `REF_COUNT; r++) begin
         ref_irq_set[r] = ref_fail_irq_mask_reg[r]
            & |(mon_set[r*`FLAG_NIBBLE +: `FLAG_NIBBLE]
                & mon_mask[r*`FLAG_NIBBLE +: `FLAG_NIBBLE]);
      end
   end

   // Sticky reference failure interrupt status
   sticky_flag_bank #(
      .WIDTH(4)
   ) u_ref_irq (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .set_vec(ref_irq_set),
      .clr_vec(ref_irq_clr),
      .flag_vec(ref_irq_status)
   );

   // interleave freeze and unlock per loop
   always_comb begin
      for (int n = 0; n < `LOOP_COUNT; n++) begin
         loop_set[2*n] = loop_freeze_event[n] & loop_event_irq_mask_reg[2*n];
         loop_set[2*n+1] = loop_unlock_event[n] & loop_event_irq_mask_reg[2*n+1];
      end
   end

   sticky_flag_bank #(
      .WIDTH(8)
   ) u_loop_status (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .set_vec(loop_set),
      .clr_vec(loop_clr),
      .flag_vec(loop_status)
   );

   // irq follows any status bit; looks at next state so it tracks the flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |((ref_irq_status & ~ref_irq_clr) | ref_irq_set)
            | |((loop_status & ~loop_clr) | loop_set);
      end
   end

   // Writable registers; flag registers ignore writes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_fail_irq_mask_reg <= `RST_IRQ_MASK;
         loop_event_irq_mask_reg <= `RST_IRQ_MASK;
         ref_monitor_fail_mask_hi_reg <= `RST_MON_MASK;
         ref_monitor_fail_mask_lo_reg <= `RST_MON_MASK;
         loss_pin_select_reg <= `RST_LOSS_PIN_SELECT;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            // Upper nibble is reserved and held at zero
            `ADDR_REF_FAIL_IRQ_MASK: ref_fail_irq_mask_reg <= {4'h0, reg_req.wdata[3:0]};
            `ADDR_LOOP_EVENT_IRQ_MASK: loop_event_irq_mask_reg <= reg_req.wdata;
            `ADDR_MON_MASK_HI: ref_monitor_fail_mask_hi_reg <= reg_req.wdata;
            `ADDR_MON_MASK_LO: ref_monitor_fail_mask_lo_reg <= reg_req.wdata;
            `ADDR_LOSS_PIN_SELECT: loss_pin_select_reg <= reg_req.wdata;
            default: loss_pin_select_reg <= loss_pin_select_reg;
         endcase
      end
   end

   // read map, lower reference in low nibble
   always_comb begin
      case (reg_req.addr)
         `ADDR_REF_FAIL_IRQ_STATUS: read_value = {4'h0, ref_irq_status};
         `ADDR_LOOP_EVENT_STATUS: read_value = loop_status;
         `ADDR_REF_FAIL_IRQ_MASK: read_value = ref_fail_irq_mask_reg;
         `ADDR_LOOP_EVENT_IRQ_MASK: read_value = loop_event_irq_mask_reg;
         `ADDR_MON_FLAGS_HI: read_value = mon_flags[15:8];
         `ADDR_MON_FLAGS_LO: read_value = mon_flags[7:0];
         `ADDR_MON_MASK_HI: read_value = ref_monitor_fail_mask_hi_reg;
         `ADDR_MON_MASK_LO: read_value = ref_monitor_fail_mask_lo_reg;
         `ADDR_LOSS_PIN_SELECT: read_value = loss_pin_select_reg;
         // Unmapped addresses read as zero
         default: read_value = `RST_READ_DATA;
      endcase
   end

   // Read data registered one cycle after the strobe, held until next read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `RST_READ_DATA;
      end else if (read_hit_valid) begin
         reg_rdata <= read_value;
      end
   end

endmodule

// ---- event_flags_monitor.sv ----
// Port checker for the event flag block
`timescale 1ns/100ps
module event_flags_monitor
   import event_flags_pkg::*;
#(
   parameter int LOSS_PIN_COUNT = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register access
   input wire reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   // Event inputs
   input wire logic [LOSS_PIN_COUNT-1:0] loss_pin,
   input wire logic [3:0] single_period_fail,
   input wire logic [3:0] rough_rate_fail,
   input wire logic [3:0] settle_guard_expire,
   input wire logic [3:0] loop_freeze_event,
   input wire logic [3:0] loop_unlock_event,
   // Interrupt
   input wire logic irq
);
   // Short names for the request fields
   wire logic rd = reg_req.rd;
   wire logic [7:0] a = reg_req.addr;
   // Pin routed to reference 0, mirrored from writes to the select register
   logic [1:0] sel0_reg;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sel0_reg <= 2'b00;
      end else if (reg_req.wr && a == 8'h10) begin
         sel0_reg <= reg_req.wdata[1:0];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   AST_IRQ_HOLD: assert property (
      irq && !(rd && (a == 8'h02 || a == 8'h03)) |=> irq) else $error("irq lost");
   AST_UNMAPPED: assert property (
      rd && !(a inside {[8'h02:8'h09], 8'h10}) |=> reg_rdata == 8'h00) else $error("unmapped");
   AST_MASK_NIBBLE: assert property (
      rd && a == 8'h04 |=> reg_rdata[7:4] == 4'h0) else $error("mask nibble");
   AST_MASK_READBACK: assert property (
      reg_req.wr && a == 8'h05 ##1 rd && a == 8'h05 |=> reg_rdata == $past(reg_req.wdata, 2))
      else $error("loop mask readback");
   AST_SINGLE_FLAG: assert property (
      single_period_fail[0] ##1 !rd ##1 rd && a == 8'h07 |=> reg_rdata[1]) else $error("single");
   AST_ROUGH_FLAG: assert property (
      rough_rate_fail[3] ##1 !rd ##1 rd && a == 8'h06 |=> reg_rdata[6]) else $error("rough");
   AST_GUARD_FLAG: assert property (
      settle_guard_expire[1] ##1 !rd ##1 rd && a == 8'h07 |=> reg_rdata[7]) else $error("guard");
   AST_LOSS_FLAG: assert property (
      $rose(loss_pin[0]) && sel0_reg == 2'b00 && !reg_req.wr
      ##1 (loss_pin[0] && !rd && !reg_req.wr) [*3] ##1 rd && a == 8'h07 |=> reg_rdata[0])
      else $error("loss");
endmodule
bind ref_monitor_dpll_event_flags event_flags_monitor #(
   .LOSS_PIN_COUNT(LOSS_PIN_COUNT)
) i_event_flags_monitor (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .loss_pin(loss_pin), .single_period_fail(single_period_fail),
   .rough_rate_fail(rough_rate_fail), .settle_guard_expire(settle_guard_expire),
   .loop_freeze_event(loop_freeze_event), .loop_unlock_event(loop_unlock_event), .irq(irq)
);

// ---- phy_loss_model.sv ----
// Line-side PHY model driving the loss pins
`timescale 1ns/100ps
module phy_loss_model #(
   parameter int N = 4
) (
   // Link state, one bit per pin
   input wire logic [N-1:0] link_down,
   // Loss pins, off the clock grid
   output logic [N-1:0] loss_pin
);
   // Pins move a few ns late so they never align with the clock edge
   initial loss_pin = '0;
   always @(link_down) loss_pin <= #7 link_down;
endmodule

// ---- ref_monitor_dpll_event_flags_bench.sv ----
// Self-checking bench for the event flag block
`timescale 1ns/100ps
module ref_monitor_dpll_event_flags_bench;
   import event_flags_pkg::*;
   // Offsets with reset values; 0x0c is unmapped
   localparam logic [7:0] ra [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h10, 8'h0c};
   localparam logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h66, 8'h66, 8'h00, 8'h00};
   logic clk_sys = 1'b0;
   logic rst_b;
   reg_req_type req;
   logic [7:0] reg_rdata;
   logic [3:0] link_down;
   logic [3:0] loss_pin;
   // Strobes: freeze, unlock, single, rough, guard
   logic [19:0] evs;
   logic irq;
   int mismatches = 0;
   int n_checks = 0;
   always #20 clk_sys = ~clk_sys;
   phy_loss_model #(.N(4)) i_phy_loss_model (.link_down(link_down), .loss_pin(loss_pin));
   ref_monitor_dpll_event_flags #(.LOSS_PIN_COUNT(4)) i_ref_monitor_dpll_event_flags (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(req), .reg_rdata(reg_rdata),
      .loss_pin(loss_pin), .loop_freeze_event(evs[3:0]), .loop_unlock_event(evs[7:4]),
      .single_period_fail(evs[11:8]), .rough_rate_fail(evs[15:12]),
      .settle_guard_expire(evs[19:16]), .irq(irq));
   task finish_test;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // Request held one edge, replaced by the next call
   task bus(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 req = '{rd: r, wr: w, addr: a, wdata: d};
   endtask
   task idle;
      bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b0, 1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b1, 1'b0, a, 8'h00);
      idle;
      check(reg_rdata, exp);
   endtask
   // One-cycle strobe on event bit b
   task pulse(input int b);
      idle;
      evs = 20'h00001 << b;
      idle;
      evs = '0;
   endtask
   task chk_irq(input logic e);
      check({7'h00, irq}, {7'h00, e});
   endtask
   task t_regs;
      chk_irq(1'b0);
      for (int i = 0; i < 10; i++) begin
         rdc(ra[i], rv[i]);
      end
      wr(8'h07, 8'hff);
      wr(8'h0c, 8'hff);
      wr(8'h04, 8'hff);
      rdc(8'h07, 8'h00);
      rdc(8'h0c, 8'h00);
      rdc(8'h04, 8'h0f);
      wr(8'h04, 8'h00);
   endtask
   task t_loop;
      logic [7:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         wr(8'h05, ~m);
         pulse(4 * (i % 2) + i / 2);
         chk_irq(1'b0);
         rdc(8'h03, 8'h00);
         wr(8'h05, m);
         rdc(8'h05, m);
         pulse(4 * (i % 2) + i / 2);
         chk_irq(1'b1);
         rdc(8'h03, m);
         chk_irq(1'b0);
      end
   endtask
   task t_mon;
      logic [7:0] m;
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h00);
      wr(8'h04, 8'h0f);
      for (int r = 0; r < 4; r++) begin
         for (int k = 1; k < 4; k++) begin
            m = 8'h01 << (4 * (r % 2) + k);
            pulse(4 + 4 * k + r);
            rdc(r < 2 ? 8'h07 : 8'h06, m);
            rdc(r < 2 ? 8'h07 : 8'h06, 8'h00);
         end
      end
      chk_irq(1'b0);
   endtask
   task t_loss;
      idle;
      link_down = 4'h1;
      repeat (3) idle;
      rdc(8'h07, 8'h11);
      rdc(8'h06, 8'h11);
      link_down = 4'h0;
      wr(8'h10, 8'h08);
      repeat (4) idle;
      link_down = 4'h4;
      repeat (4) idle;
      rdc(8'h07, 8'h10);
      rdc(8'h06, 8'h00);
   endtask
   task t_refirq;
      wr(8'h04, 8'h01);
      wr(8'h09, 8'h02);
      pulse(12);
      chk_irq(1'b0);
      rdc(8'h02, 8'h00);
      pulse(8);
      chk_irq(1'b1);
      rdc(8'h02, 8'h01);
      chk_irq(1'b0);
      rdc(8'h07, 8'h06);
   endtask
   initial begin
      rst_b = 1'b0;
      req = '0;
      evs = '0;
      link_down = '0;
      repeat (12) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      t_regs;
      t_loop;
      t_mon;
      t_loss;
      t_refirq;
      idle;
      finish_test;
   end
   // Run needs well under a thousand cycles; cut off a hang
   initial begin
      #200000;
      mismatches++;
      finish_test;
   end
endmodule
